// File: logic/ipwd_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipwd_defines.svh"
module ipwd_device #(
    parameter int unsigned SEC_CYCLES = `IPWD_CLK_HZ
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    ipwd_if.dev       bus,
    input  wire logic mouse_evt,
    input  wire logic kbd_evt,
    input  wire logic sel_reset,
    output logic      wdt_irq,
    output logic      wdt_rst
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] ms_sync;
    logic [1:0] kb_sync;
    logic [1:0] sr_sync;
    logic       ms_prev;
    logic       kb_prev;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ms_sync <= 2'h0;
            kb_sync <= 2'h0;
            sr_sync <= 2'h0;
            ms_prev <= 1'b0;
            kb_prev <= 1'b0;
        end else begin
            ms_sync <= {ms_sync[0], mouse_evt};
            kb_sync <= {kb_sync[0], kbd_evt};
            sr_sync <= {sr_sync[0], sel_reset};
            ms_prev <= ms_sync[1];
            kb_prev <= kb_sync[1];
        end
    end
    wire logic ms_pulse = ms_sync[1] & ~ms_prev;
    wire logic kb_pulse = kb_sync[1] & ~kb_prev;

    // ----------------------------------------------------------------
    // Configuration port
    // ----------------------------------------------------------------
    ipwd_pkg::ipwd_cfg_t cfg;
    ipwd_pkg::ipwd_cfg_t next_cfg;
    logic [7:0] idx;
    logic [7:0] next_idx;
    logic [7:0] ldev;
    logic [7:0] next_ldev;
    logic       act;
    logic       next_act;
    logic       unit_min;
    logic       next_unit_min;
    logic [7:0] count_cfg;
    logic [7:0] next_count_cfg;
    logic       en_ms;
    logic       next_en_ms;
    logic       en_kb;
    logic       next_en_kb;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       load;
    logic       force_to;

    // Timer state
    logic [7:0]  remain;
    logic [7:0]  next_remain;
    logic [27:0] pre;
    logic [27:0] next_pre;
    logic [5:0]  mins;
    logic [5:0]  next_mins;
    logic        stat;
    logic        next_stat;
    logic        irq_q;
    logic        next_irq_q;
    logic        rst_q;
    logic        next_rst_q;

    wire logic open   = (cfg == ipwd_pkg::IPWD_OPEN);
    wire logic wdt_on = (ldev == `IPWD_LDEV_WDT);

    always_comb begin
        next_cfg       = cfg;
        next_idx       = idx;
        next_ldev      = ldev;
        next_act       = act;
        next_unit_min  = unit_min;
        next_count_cfg = count_cfg;
        next_en_ms     = en_ms;
        next_en_kb     = en_kb;
        next_rdata     = rdata;
        load           = 1'b0;
        force_to       = 1'b0;
        if (bus.io_wr && bus.io_port == `IPWD_ADDR_PORT) begin
            case (cfg)
                ipwd_pkg::IPWD_LOCKED: begin
                    if (bus.io_wdata == `IPWD_KEY_UNLOCK)
                        next_cfg = ipwd_pkg::IPWD_KEY1;
                end
                ipwd_pkg::IPWD_KEY1: begin
                    // Any other value breaks the pair
                    next_cfg = (bus.io_wdata == `IPWD_KEY_UNLOCK) ?
                               ipwd_pkg::IPWD_OPEN : ipwd_pkg::IPWD_LOCKED;
                end
                ipwd_pkg::IPWD_OPEN: begin
                    if (bus.io_wdata == `IPWD_KEY_LOCK)
                        next_cfg = ipwd_pkg::IPWD_LOCKED;
                    else
                        next_idx = bus.io_wdata;
                end
                default: next_cfg = ipwd_pkg::IPWD_LOCKED;
            endcase
        end
        if (bus.io_wr && bus.io_port == `IPWD_DATA_PORT && open) begin
            if (idx == `IPWD_REG_LDEV)
                next_ldev = bus.io_wdata;
            else if (wdt_on) begin
                case (idx)
                    `IPWD_REG_ACT:   next_act = (bus.io_wdata == `IPWD_ACT_ON);
                    `IPWD_REG_UNIT:  next_unit_min = bus.io_wdata[`IPWD_BIT_UNIT];
                    `IPWD_REG_COUNT: begin
                        next_count_cfg = bus.io_wdata;
                        load           = 1'b1;
                    end
                    `IPWD_REG_CTRL: begin
                        next_en_ms = bus.io_wdata[`IPWD_BIT_MOUSE];
                        next_en_kb = bus.io_wdata[`IPWD_BIT_KBD];
                        force_to   = bus.io_wdata[`IPWD_BIT_FORCE];
                    end
                    default: ;
                endcase
            end
        end
        if (bus.io_rd && bus.io_port == `IPWD_DATA_PORT) begin
            next_rdata = `IPWD_ZERO8;
            if (open && wdt_on) begin
                case (idx)
                    `IPWD_REG_UNIT:  next_rdata[`IPWD_BIT_UNIT] = unit_min;
                    `IPWD_REG_COUNT: next_rdata = remain;
                    `IPWD_REG_CTRL: begin
                        next_rdata[`IPWD_BIT_MOUSE] = en_ms;
                        next_rdata[`IPWD_BIT_KBD]   = en_kb;
                        next_rdata[`IPWD_BIT_STAT]  = stat;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg       <= ipwd_pkg::IPWD_LOCKED;
            idx       <= `IPWD_ZERO8;
            ldev      <= `IPWD_ZERO8;
            act       <= 1'b0;
            unit_min  <= 1'b0;
            count_cfg <= `IPWD_ZERO8;
            en_ms     <= 1'b0;
            en_kb     <= 1'b0;
            rdata     <= `IPWD_ZERO8;
        end else begin
            cfg       <= next_cfg;
            idx       <= next_idx;
            ldev      <= next_ldev;
            act       <= next_act;
            unit_min  <= next_unit_min;
            count_cfg <= next_count_cfg;
            en_ms     <= next_en_ms;
            en_kb     <= next_en_kb;
            rdata     <= next_rdata;
        end
    end
    assign bus.io_rdata = rdata;

    // ----------------------------------------------------------------
    // Timer
    // ----------------------------------------------------------------
    wire logic sec_tick  = (pre == 28'(SEC_CYCLES - 1));
    wire logic unit_tick = sec_tick &&
                           (!unit_min || mins == 6'(`IPWD_SEC_PER_MIN - 1));
    wire logic restart   = (ms_pulse && en_ms) || (kb_pulse && en_kb);

    always_comb begin
        next_remain = remain;
        next_pre    = sec_tick ? 28'h0 : pre + 28'h1;
        next_mins   = mins;
        next_stat   = stat;
        next_irq_q  = 1'b0;
        next_rst_q  = 1'b0;
        if (sec_tick)
            next_mins = (mins == 6'(`IPWD_SEC_PER_MIN - 1)) ? 6'h0 : mins + 6'h1;
        if (load) begin
            next_remain = count_cfg_w();
            next_pre    = 28'h0;
            next_mins   = 6'h0;
            if (count_cfg_w() != `IPWD_ZERO8)
                next_stat = 1'b0;
        end else if (restart && remain != `IPWD_ZERO8) begin
            next_remain = count_cfg;
            next_pre    = 28'h0;
            next_mins   = 6'h0;
        end else if (act && remain != `IPWD_ZERO8 && unit_tick) begin
            next_remain = remain - 8'h01;
        end
        // Expiry or forced timeout; a same-cycle load or restart cancels the expiry
        if ((act && remain == 8'h01 && unit_tick && !load && !restart)
            || (act && force_to)) begin
            next_stat  = 1'b1;
            next_irq_q = !sr_sync[1];
            next_rst_q = sr_sync[1];
        end
    end

    function automatic logic [7:0] count_cfg_w();
        return bus.io_wdata;
    endfunction

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            remain <= `IPWD_ZERO8;
            pre    <= 28'h0;
            mins   <= 6'h0;
            stat   <= 1'b0;
            irq_q  <= 1'b0;
            rst_q  <= 1'b0;
        end else begin
            remain <= next_remain;
            pre    <= next_pre;
            mins   <= next_mins;
            stat   <= next_stat;
            irq_q  <= next_irq_q;
            rst_q  <= next_rst_q;
        end
    end
    assign wdt_irq = irq_q;
    assign wdt_rst = rst_q;
endmodule
`default_nettype wire

// File: logic/ipwd_defines.svh
`ifndef IPWD_DEFINES_SVH
`define IPWD_DEFINES_SVH

// ----------------------------------------------------------------
// Ports and keys
// ----------------------------------------------------------------
`define IPWD_ADDR_PORT     1'b0
`define IPWD_DATA_PORT     1'b1
`define IPWD_KEY_UNLOCK    8'h87
`define IPWD_KEY_LOCK      8'haa
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IPWD_REG_LDEV      8'h07
`define IPWD_REG_ACT       8'h30
`define IPWD_REG_UNIT      8'hf0
`define IPWD_REG_COUNT     8'hf1
`define IPWD_REG_CTRL      8'hf2
`define IPWD_LDEV_WDT      8'h08
`define IPWD_ACT_ON        8'h01
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define IPWD_BIT_UNIT      3
`define IPWD_BIT_MOUSE     7
`define IPWD_BIT_KBD       6
`define IPWD_BIT_FORCE     5
`define IPWD_BIT_STAT      4
`define IPWD_ZERO8         8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IPWD_CLK_HZ        200000000
`define IPWD_SEC_PER_MIN   60
`define IPWD_HOST_GAP      4'h2
`endif

// File: logic/ipwd_pkg.sv
`default_nettype none
package ipwd_pkg;
    typedef enum logic [1:0] {
        IPWD_LOCKED = 2'b00,
        IPWD_KEY1   = 2'b01,
        IPWD_OPEN   = 2'b11
    } ipwd_cfg_t;

    typedef enum logic [1:0] {
        IPWD_H_IDLE = 2'b00,
        IPWD_H_IDX  = 2'b01,
        IPWD_H_DATA = 2'b11,
        IPWD_H_WAIT = 2'b10
    } ipwd_host_t;
endpackage
`default_nettype wire

// File: logic/ipwd_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ipwd_if;
    logic       io_wr;
    logic       io_rd;
    logic       io_port;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;

    modport dev (
        input  io_wr,
        input  io_rd,
        input  io_port,
        input  io_wdata,
        output io_rdata
    );
    modport host (
        output io_wr,
        output io_rd,
        output io_port,
        output io_wdata,
        input  io_rdata
    );
endinterface
`default_nettype wire

// File: logic/ipwd_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipwd_defines.svh"
module ipwd_host (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    ipwd_if.host            bus,
    input  wire logic       req,
    input  wire logic       req_rd,
    input  wire logic       req_raw,
    input  wire logic [7:0] req_idx,
    input  wire logic [7:0] req_data,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rd_data
);
    // ----------------------------------------------------------------
    // Index then data sequencer
    // ----------------------------------------------------------------
    ipwd_pkg::ipwd_host_t st;
    ipwd_pkg::ipwd_host_t next_st;
    logic       wr;
    logic       next_wr;
    logic       rd;
    logic       next_rd;
    logic       port;
    logic       next_port;
    logic [7:0] wdata;
    logic [7:0] next_wdata;
    logic [7:0] dval;
    logic [7:0] next_dval;
    logic       isrd;
    logic       next_isrd;
    logic [3:0] gap;
    logic [3:0] next_gap;
    logic       next_busy;
    logic       next_done;
    logic [7:0] next_rd_data;

    always_comb begin
        next_st      = st;
        next_wr      = 1'b0;
        next_rd      = 1'b0;
        next_port    = port;
        next_wdata   = wdata;
        next_dval    = dval;
        next_isrd    = isrd;
        next_gap     = gap;
        next_busy    = busy;
        next_done    = 1'b0;
        next_rd_data = rd_data;
        case (st)
            ipwd_pkg::IPWD_H_IDLE: begin
                if (req) begin
                    // Raw requests write req_data to the address port (keys, lock)
                    next_wr    = 1'b1;
                    next_port  = `IPWD_ADDR_PORT;
                    next_wdata = req_raw ? req_data : req_idx;
                    next_dval  = req_data;
                    next_isrd  = req_rd;
                    next_busy  = 1'b1;
                    next_st    = req_raw ? ipwd_pkg::IPWD_H_WAIT : ipwd_pkg::IPWD_H_IDX;
                end
            end
            ipwd_pkg::IPWD_H_IDX: begin
                next_port  = `IPWD_DATA_PORT;
                next_wdata = dval;
                next_wr    = !isrd;
                next_rd    = isrd;
                next_gap   = `IPWD_HOST_GAP;
                next_st    = ipwd_pkg::IPWD_H_DATA;
            end
            ipwd_pkg::IPWD_H_DATA: begin
                // Device answers one cycle after the read strobe
                next_gap = gap - 4'h1;
                if (gap == 4'h1) begin
                    if (isrd)
                        next_rd_data = bus.io_rdata;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_st   = ipwd_pkg::IPWD_H_IDLE;
                end
            end
            ipwd_pkg::IPWD_H_WAIT: begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_st   = ipwd_pkg::IPWD_H_IDLE;
            end
            default: next_st = ipwd_pkg::IPWD_H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st      <= ipwd_pkg::IPWD_H_IDLE;
            wr      <= 1'b0;
            rd      <= 1'b0;
            port    <= 1'b0;
            wdata   <= 8'h00;
            dval    <= 8'h00;
            isrd    <= 1'b0;
            gap     <= 4'h0;
            busy    <= 1'b0;
            done    <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            st      <= next_st;
            wr      <= next_wr;
            rd      <= next_rd;
            port    <= next_port;
            wdata   <= next_wdata;
            dval    <= next_dval;
            isrd    <= next_isrd;
            gap     <= next_gap;
            busy    <= next_busy;
            done    <= next_done;
            rd_data <= next_rd_data;
        end
    end
    assign bus.io_wr    = wr;
    assign bus.io_rd    = rd;
    assign bus.io_port  = port;
    assign bus.io_wdata = wdata;
endmodule
`default_nettype wire

// File: testbench/ipwd_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ipwd_assertions (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic       io_port,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       sel_reset,
    input wire logic       wdt_irq,
    input wire logic       wdt_rst
);
    // ------------------------------------------------------------
    // Shadow of key state, index, selection, unit and status
    // ------------------------------------------------------------
    logic [1:0] keys, next_keys;
    logic [7:0] idx, next_idx, ldev, next_ldev;
    logic       unit, next_unit, stat, next_stat, stat_now, wd, hit, rdq;

    always_comb begin
        rdq = io_rd && io_port;
        stat_now = stat || wdt_irq || wdt_rst;
        wd = io_wr && io_port && keys == 2'h2;
        hit = idx == 8'h07 || ldev == 8'h08;
        next_keys = keys;
        next_idx = idx;
        next_ldev = ldev;
        next_unit = unit;
        next_stat = stat;
        if (io_wr && !io_port) begin
            if (keys == 2'h2) begin
                next_idx = io_wdata;
                next_keys = (io_wdata == 8'haa) ? 2'h0 : 2'h2;
            end else begin
                next_keys = (io_wdata == 8'h87) ? keys + 2'h1 : 2'h0;
            end
        end
        if (wd && idx == 8'h07) next_ldev = io_wdata;
        if (wd && hit && idx == 8'hf0) next_unit = io_wdata[3];
        // The pulse shows in the same cycle as the device status bit, so a later clear wins
        if (wdt_irq || wdt_rst) next_stat = 1'b1;
        if (wd && hit && idx == 8'hf1 && io_wdata != 8'h00) next_stat = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            keys <= 2'h0;
            idx  <= 8'h00;
            ldev <= 8'h00;
            unit <= 1'b0;
            stat <= 1'b0;
        end else begin
            keys <= next_keys;
            idx  <= next_idx;
            ldev <= next_ldev;
            unit <= next_unit;
            stat <= next_stat;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    rd_pulse_a: assert property (io_rd |=> !io_rd)
        else $error("read strobe longer than one cycle");
    no_overlap_a: assert property (!(io_wr && io_rd))
        else $error("read and write strobes together");
    rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    locked_read_a: assert property (rdq && keys != 2'h2 |=> io_rdata == 8'h00)
        else $error("locked read returned data");
    unsel_read_a: assert property (rdq && keys == 2'h2 && !hit |=> io_rdata == 8'h00)
        else $error("unselected read returned data");
    unit_read_a: assert property (rdq && keys == 2'h2 && hit && idx == 8'hf0
        |=> io_rdata == {4'h0, $past(unit), 3'h0}) else $error("unit read wrong");
    status_read_a: assert property (rdq && keys == 2'h2 && hit && idx == 8'hf2
        |=> io_rdata[5:4] == {1'b0, $past(stat_now)}) else $error("status read wrong");
    irq_route_a: assert property (wdt_irq |-> !sel_reset && !wdt_rst)
        else $error("interrupt raised while reset selected");
    rst_route_a: assert property (wdt_rst |-> sel_reset)
        else $error("reset raised while interrupt selected");
    expiry_pulse_a: assert property (wdt_irq || wdt_rst |=> !(wdt_irq || wdt_rst) [*2])
        else $error("expiry output not a single pulse");
endmodule
`default_nettype wire

// File: testbench/indexed_port_watchdog_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module indexed_port_watchdog_timer_tb;
    localparam int S = 4;
    logic       ref_clk   = 1'b0;
    logic       rstn      = 1'b0;
    logic       req       = 1'b0;
    logic       req_rd    = 1'b0;
    logic       req_raw   = 1'b0;
    logic       mouse_evt = 1'b0;
    logic       kbd_evt   = 1'b0;
    logic       sel_reset = 1'b0;
    logic [7:0] req_idx   = 8'h00;
    logic [7:0] req_data  = 8'h00;
    logic [7:0] rd_data, v;
    logic       busy, done, wdt_irq, wdt_rst, last_rst;
    int         fails     = 0;
    int         n_checks  = 0;
    int         npulse    = 0;
    int         mark      = 0;

    ipwd_if u_ipwd_if ();
    ipwd_host u_ipwd_host (.ref_clk(ref_clk), .rstn(rstn), .bus(u_ipwd_if), .req(req),
        .req_rd(req_rd), .req_raw(req_raw), .req_idx(req_idx), .req_data(req_data),
        .busy(busy), .done(done), .rd_data(rd_data));
    ipwd_device #(.SEC_CYCLES(S)) u_ipwd_device (.ref_clk(ref_clk), .rstn(rstn),
        .bus(u_ipwd_if), .mouse_evt(mouse_evt), .kbd_evt(kbd_evt), .sel_reset(sel_reset),
        .wdt_irq(wdt_irq), .wdt_rst(wdt_rst));
    ipwd_assertions u_ipwd_assertions (.ref_clk(ref_clk), .rstn(rstn),
        .io_wr(u_ipwd_if.io_wr), .io_rd(u_ipwd_if.io_rd), .io_port(u_ipwd_if.io_port),
        .io_wdata(u_ipwd_if.io_wdata), .io_rdata(u_ipwd_if.io_rdata),
        .sel_reset(sel_reset), .wdt_irq(wdt_irq), .wdt_rst(wdt_rst));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Expiry pulses last one cycle and may land inside a host op, so count them
    always @(posedge ref_clk) begin
        if ((wdt_irq | wdt_rst) === 1'b1) begin
            npulse++;
            last_rst = wdt_rst;
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic op(input logic rd, input logic raw, input logic [7:0] i, input logic [7:0] d);
        int n = 0;
        @(negedge ref_clk);
        req = 1'b1;
        req_rd = rd;
        req_raw = raw;
        req_idx = i;
        req_data = d;
        @(negedge ref_clk);
        req = 1'b0;
        chk("host busy", 8'h01, {7'h0, busy === 1'b1});
        while (done !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk("host done", 8'h01, {7'h0, done === 1'b1});
        chk("host idle", 8'h01, {7'h0, busy === 1'b0});
        v = rd_data;
    endtask

    task automatic key(input logic [7:0] d);
        op(1'b0, 1'b1, 8'h00, d);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        op(1'b0, 1'b0, i, d);
    endtask

    task automatic rd(input logic [7:0] i);
        op(1'b1, 1'b0, i, 8'h00);
    endtask

    task automatic quiet(input int cyc);
        repeat (cyc) @(negedge ref_clk);
        chk("no expiry", 8'h00, 8'(npulse - mark));
    endtask

    task automatic pulse(input int lo, input int hi, input logic exp_rst);
        int n = 0;
        while (npulse == mark && n < hi) begin
            @(negedge ref_clk);
            n++;
        end
        chk("expiry in window", 8'h01, {7'h0, npulse == mark + 1 && n >= lo});
        chk("expiry output", {7'h0, exp_rst}, {7'h0, last_rst});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        key(8'h87);
        key(8'h87);
        wr(8'h07, 8'h08);
        for (int i = 0; i < 3; i++) begin
            rd(8'hf0 + 8'(i));
            chk("reset value", 8'h00, v);
        end
    endtask

    task automatic t_lock;
        wr(8'hf0, 8'h08);
        key(8'haa);
        rd(8'hf0);
        chk("locked read", 8'h00, v);
        key(8'h87);
        key(8'h55);
        key(8'h87);
        rd(8'hf0);
        chk("split key read", 8'h00, v);
        key(8'haa);
        key(8'h87);
        key(8'h87);
        rd(8'hf0);
        chk("unit read", 8'h08, v);
        wr(8'h07, 8'h00);
        rd(8'hf0);
        chk("unselected read", 8'h00, v);
        wr(8'h07, 8'h08);
        wr(8'hf0, 8'h00);
    endtask

    task automatic t_expire;
        mark = npulse;
        wr(8'hf1, 8'h03);
        quiet(6 * S);
        wr(8'h30, 8'h01);
        mark = npulse;
        wr(8'hf1, 8'h03);
        pulse(S + 2, 3 * S + 2, 1'b0);
        rd(8'hf2);
        chk("timeout status", 8'h10, v);
        mark = npulse;
        quiet(5 * S);
        rd(8'hf2);
        chk("status held", 8'h10, v);
        wr(8'hf1, 8'h03);
        rd(8'hf2);
        chk("status cleared", 8'h00, v);
        mark = npulse;
        wr(8'hf1, 8'h06);
        pulse(5 * S - 2, 6 * S + 2, 1'b0);
        wr(8'hf1, 8'h03);
        mark = npulse;
        wr(8'hf1, 8'h00);
        quiet(6 * S);
        wr(8'hf0, 8'h08);
        mark = npulse;
        wr(8'hf1, 8'h02);
        quiet(50 * S);
        pulse(0, 75 * S, 1'b0);
        wr(8'hf0, 8'h00);
    endtask

    // Mouse, keyboard, and each one while only the other is enabled
    task automatic t_evt;
        logic [7:0] ctl [4] = '{8'h80, 8'h40, 8'h40, 8'h80};
        for (int i = 0; i < 4; i++) begin
            wr(8'hf2, ctl[i]);
            mark = npulse;
            wr(8'hf1, 8'h03);
            repeat (5) @(negedge ref_clk);
            if (i % 2 == 1) kbd_evt = 1'b1;
            else mouse_evt = 1'b1;
            @(negedge ref_clk);
            mouse_evt = 1'b0;
            kbd_evt = 1'b0;
            if (i < 2) pulse(2 * S + 1, 4 * S + 2, 1'b0);
            else pulse(0, 2 * S - 1, 1'b0);
        end
    endtask

    task automatic t_force;
        sel_reset = 1'b1;
        mark = npulse;
        wr(8'hf2, 8'h20);
        pulse(0, 2, 1'b1);
        rd(8'hf2);
        chk("force bit clear", 8'h10, v);
        wr(8'h30, 8'h00);
        mark = npulse;
        wr(8'hf2, 8'h20);
        quiet(4);
    endtask

    task automatic wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        t_reset();
        t_lock();
        t_expire();
        t_evt();
        t_force();
        wrap_up();
    end

    // Whole run is about 860 cycles
    initial begin
        #40000;
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire
